// ==== rtl/ltpc_pkg.sv ====
// Package: constants, types and helpers of the LCD timing and power control
package ltpc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	// Half period of the internal display oscillator, in ns
	localparam int OSC_HALF_NS = 160;
	localparam int OSC_HALF_CYC =
		(OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Panel geometry
	// ------------------------------------------------------------
	localparam int ROWS_DEF = 65;
	localparam int ROW_W = 7;
	localparam logic [5:0] CONTRAST_TOP = 6'h3F;

	// ------------------------------------------------------------
	// Commands and settings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_POWER = 3'h0,
		CMD_CONTRAST = 3'h1,
		CMD_RATIO = 3'h2,
		CMD_ROW_DIR = 3'h3,
		CMD_DISPLAY = 3'h4
	} ltpc_cmd_t;

	typedef struct packed {
		logic [2:0] power;
		logic [5:0] contrast;
		logic [2:0] ratio;
		logic row_rev;
		logic disp_on;
	} ltpc_cfg_t;

	localparam ltpc_cfg_t CFG_RST = 14'h0000;

	// Regulator gain times ten for each divider-ratio code
	function automatic logic [6:0] ltpc_gain_x10(input logic [2:0] code);
		logic [6:0] g;
		g = 7'h00;
		unique case (code)
			3'h0: g = 7'h1E;
			3'h1: g = 7'h23;
			3'h2: g = 7'h28;
			3'h3: g = 7'h2D;
			3'h4: g = 7'h32;
			3'h5: g = 7'h37;
			3'h6: g = 7'h3C;
			3'h7: g = 7'h40;
		endcase
		return g;
	endfunction : ltpc_gain_x10

	// Drive level: bit 1 marks a scanned row, bit 0 the phase
	function automatic logic [1:0] ltpc_drive_level(input logic pix,
			input logic row_on, input logic pol);
		logic [1:0] lv;
		lv = row_on ? {1'b1, pol} : {1'b0, pix ^ pol};
		return lv;
	endfunction : ltpc_drive_level

endpackage : ltpc_pkg

// ==== rtl/ltpc_top.sv ====
// Module: display timing and supply control of the LCD driver
// Notes on behaviour
// - Row timing and polarity derive from display clock
// - Secondaries take polarity, clock, blank from primary
// - Primary drives polarity and blank signals
// - Row scan order ascending or reversed by command
// - Drive level from pixel, row scan, polarity
// - Supply stages enabled only when primary
// - Three bits switch booster, regulator, follower
// - Contrast level equals 63 minus register value
// - Divider ratio picks one of eight gains
// - Oscillator runs only with both straps high
module ltpc_top import ltpc_pkg::*; #(
	parameter int ROWS = ROWS_DEF
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic CMD_WR,
	input wire logic [2:0] CMD_SEL,
	input wire logic [5:0] CMD_DATA,
	input wire logic PRIMARY_SEL,
	input wire logic OSCILLATOR_SOURCE_SELECT,
	input wire logic DISPLAY_TICK_PIN_I,
	output logic DISPLAY_TICK_PIN_O,
	output logic DISPLAY_TICK_PIN_OE,
	input wire logic AC_DRIVE_POLARITY_I,
	output logic AC_DRIVE_POLARITY_O,
	output logic AC_DRIVE_POLARITY_OE,
	input wire logic DISPLAY_BLANK_N_I,
	output logic DISPLAY_BLANK_N_O,
	output logic DISPLAY_BLANK_N_OE,
	input wire logic PIXEL_BIT,
	input wire logic [ROW_W-1:0] PROBE_ROW,
	output logic [ROW_W-1:0] ROW_INDEX,
	output logic ROW_TICK,
	output logic [1:0] DRIVE_LEVEL,
	output logic [2:0] SUPPLY_EN,
	output logic [5:0] CONTRAST_LEVEL,
	output logic [6:0] GAIN_X10
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic ms_s1_r, ms_s2_r, cls_s1_r, cls_s2_r;
	logic cl_s1_r, cl_s2_r, cl_s3_r;
	logic fr_s1_r, fr_s2_r, fr_s3_r;
	logic dof_s1_r, dof_s2_r;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			{ms_s1_r, ms_s2_r, cls_s1_r, cls_s2_r} <= 4'h0;
			{cl_s1_r, cl_s2_r, cl_s3_r} <= 3'h0;
			{fr_s1_r, fr_s2_r, fr_s3_r} <= 3'h0;
			{dof_s1_r, dof_s2_r} <= 2'h0;
		end else if (CE) begin
			{ms_s2_r, ms_s1_r} <= {ms_s1_r, PRIMARY_SEL};
			{cls_s2_r, cls_s1_r} <= {cls_s1_r, OSCILLATOR_SOURCE_SELECT};
			{cl_s3_r, cl_s2_r, cl_s1_r} <=
				{cl_s2_r, cl_s1_r, DISPLAY_TICK_PIN_I};
			{fr_s3_r, fr_s2_r, fr_s1_r} <=
				{fr_s2_r, fr_s1_r, AC_DRIVE_POLARITY_I};
			{dof_s2_r, dof_s1_r} <= {dof_s1_r, DISPLAY_BLANK_N_I};
		end
	end

	wire primary = ms_s2_r;
	wire osc_on = ms_s2_r & cls_s2_r;

	// ------------------------------------------------------------
	// Internal oscillator
	// ------------------------------------------------------------
	localparam logic [7:0] OSC_LAST = 8'(OSC_HALF_CYC - 1);
	logic [7:0] osc_cnt_r;
	logic osc_clk_r;
	wire osc_wrap = (osc_cnt_r == OSC_LAST);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			osc_cnt_r <= 8'h00;
			osc_clk_r <= 1'b0;
		end else if (CE) begin
			if (!osc_on) begin
				osc_cnt_r <= 8'h00;
				osc_clk_r <= 1'b0;
			end else if (osc_wrap) begin
				osc_cnt_r <= 8'h00;
				osc_clk_r <= ~osc_clk_r;
			end else begin
				osc_cnt_r <= osc_cnt_r + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Row timing and polarity
	// ------------------------------------------------------------
	localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(ROWS - 1);
	wire osc_tick = osc_on & osc_wrap & ~osc_clk_r;
	wire pin_tick = cl_s2_r & ~cl_s3_r;
	wire tick = osc_on ? osc_tick : pin_tick;
	wire fr_edge = fr_s2_r ^ fr_s3_r;

	logic [ROW_W-1:0] row_r, row_nxt;
	logic pol_r, pol_nxt;
	wire frame_end = tick & (row_r == ROW_LAST);

	always_comb begin
		row_nxt = row_r;
		if (!primary && fr_edge) begin
			row_nxt = '0;
		end else if (tick) begin
			row_nxt = frame_end ? '0 : row_r + ROW_W'(1);
		end
	end

	// Primary flips polarity each frame: one period spans two frames
	assign pol_nxt = primary ? (pol_r ^ frame_end) : fr_s2_r;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			row_r <= '0;
			pol_r <= 1'b0;
		end else if (CE) begin
			row_r <= row_nxt;
			pol_r <= pol_nxt;
		end
	end

	// ------------------------------------------------------------
	// Command settings
	// ------------------------------------------------------------
	ltpc_cfg_t cfg_r, cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (CMD_WR) begin
			unique case (CMD_SEL)
				CMD_POWER: cfg_nxt.power = CMD_DATA[2:0];
				CMD_CONTRAST: cfg_nxt.contrast = CMD_DATA;
				CMD_RATIO: cfg_nxt.ratio = CMD_DATA[2:0];
				CMD_ROW_DIR: cfg_nxt.row_rev = CMD_DATA[0];
				CMD_DISPLAY: cfg_nxt.disp_on = CMD_DATA[0];
				default: cfg_nxt = cfg_r;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	wire [ROW_W-1:0] row_idx = cfg_r.row_rev ? ROW_LAST - row_r : row_r;
	wire blank_n = primary ? cfg_r.disp_on : dof_s2_r;
	wire [1:0] lvl = blank_n ?
		ltpc_drive_level(PIXEL_BIT, PROBE_ROW == row_idx, pol_r) : 2'h0;
	wire [2:0] supply = primary ? cfg_r.power : 3'h0;
	wire [5:0] contrast = CONTRAST_TOP - cfg_r.contrast;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cfg_r <= CFG_RST;
			ROW_INDEX <= '0;
			ROW_TICK <= 1'b0;
			DRIVE_LEVEL <= 2'h0;
			SUPPLY_EN <= 3'h0;
			CONTRAST_LEVEL <= CONTRAST_TOP;
			GAIN_X10 <= ltpc_gain_x10(3'h0);
		end else if (CE) begin
			cfg_r <= cfg_nxt;
			ROW_INDEX <= row_idx;
			ROW_TICK <= tick;
			DRIVE_LEVEL <= lvl;
			SUPPLY_EN <= supply;
			CONTRAST_LEVEL <= contrast;
			GAIN_X10 <= ltpc_gain_x10(cfg_r.ratio);
		end
	end

	assign DISPLAY_TICK_PIN_O = osc_clk_r;
	assign DISPLAY_TICK_PIN_OE = osc_on;
	assign AC_DRIVE_POLARITY_O = pol_r;
	assign AC_DRIVE_POLARITY_OE = primary;
	assign DISPLAY_BLANK_N_O = cfg_r.disp_on;
	assign DISPLAY_BLANK_N_OE = primary;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_prim_drive;
		@(posedge CLK) disable iff (RESET)
		primary |-> AC_DRIVE_POLARITY_OE && DISPLAY_BLANK_N_OE;
	endproperty
	a_prim_drive: assert property (p_prim_drive)
		else $error("Primary does not drive polarity and blank");

	property p_sec_inputs;
		@(posedge CLK) disable iff (RESET)
		!primary |-> !AC_DRIVE_POLARITY_OE && !DISPLAY_BLANK_N_OE
			&& !DISPLAY_TICK_PIN_OE;
	endproperty
	a_sec_inputs: assert property (p_sec_inputs)
		else $error("Secondary drives a timing pin");

	property p_osc_run;
		@(posedge CLK) disable iff (RESET)
		CE && !(ms_s2_r && cls_s2_r) |=> !osc_clk_r && osc_cnt_r == 8'h00;
	endproperty
	a_osc_run: assert property (p_osc_run)
		else $error("Oscillator runs without both straps high");

	property p_sec_supply;
		@(posedge CLK) disable iff (RESET)
		CE && !primary |=> SUPPLY_EN == 3'h0;
	endproperty
	a_sec_supply: assert property (p_sec_supply)
		else $error("Supply stage enabled on a secondary");

	property p_power_cmd;
		@(posedge CLK) disable iff (RESET)
		CE && CMD_WR && CMD_SEL == CMD_POWER ##1 CE && primary
			|=> SUPPLY_EN == $past(CMD_DATA[2:0], 2);
	endproperty
	a_power_cmd: assert property (p_power_cmd)
		else $error("Supply enables do not follow power command");

	property p_contrast;
		@(posedge CLK) disable iff (RESET)
		CE |=> CONTRAST_LEVEL + $past(cfg_r.contrast) == 6'h3F;
	endproperty
	a_contrast: assert property (p_contrast)
		else $error("Contrast level is not 63 minus register");

	property p_gain;
		@(posedge CLK) disable iff (RESET)
		CE && cfg_r.ratio == 3'h7 |=> GAIN_X10 == 7'h40;
	endproperty
	a_gain: assert property (p_gain)
		else $error("Top divider code does not give gain 6.4");

	property p_hold;
		@(posedge CLK) disable iff (RESET)
		!(CE && CMD_WR) |=> $stable(cfg_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Setting changed without a command");

	property p_pol_frame;
		@(posedge CLK) disable iff (RESET)
		primary && $past(primary) && $changed(pol_r) |-> $past(frame_end);
	endproperty
	a_pol_frame: assert property (p_pol_frame)
		else $error("Polarity flipped away from a frame end");

	property p_row_rev;
		@(posedge CLK) disable iff (RESET)
		CE && cfg_r.row_rev |=> ROW_INDEX == ROW_LAST - $past(row_r);
	endproperty
	a_row_rev: assert property (p_row_rev)
		else $error("Reversed row order is wrong");

	property p_level;
		@(posedge CLK) disable iff (RESET)
		CE && blank_n && PROBE_ROW != row_idx
			|=> DRIVE_LEVEL == {1'b0, $past(PIXEL_BIT) ^ $past(pol_r)};
	endproperty
	a_level: assert property (p_level)
		else $error("Unscanned drive level mismatches pixel and polarity");

	property p_blank_lvl;
		@(posedge CLK) disable iff (RESET)
		CE && !blank_n |=> DRIVE_LEVEL == 2'h0;
	endproperty
	a_blank_lvl: assert property (p_blank_lvl)
		else $error("Blanked output does not drive level zero");

	property p_scan_lvl;
		@(posedge CLK) disable iff (RESET)
		CE && blank_n && PROBE_ROW == row_idx
			|=> DRIVE_LEVEL == {1'b1, $past(pol_r)};
	endproperty
	a_scan_lvl: assert property (p_scan_lvl)
		else $error("Scanned drive level mismatches polarity");

	property p_prim_supply;
		@(posedge CLK) disable iff (RESET)
		CE && primary |=> SUPPLY_EN == $past(cfg_r.power);
	endproperty
	a_prim_supply: assert property (p_prim_supply)
		else $error("Primary supply enables differ from setting");

	property p_row_step;
		@(posedge CLK) disable iff (RESET)
		CE && primary && tick && !frame_end
			|=> row_r == $past(row_r) + ROW_W'(1);
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("Row did not advance on a display tick");

	property p_row_wrap;
		@(posedge CLK) disable iff (RESET)
		CE && frame_end |=> row_r == '0;
	endproperty
	a_row_wrap: assert property (p_row_wrap)
		else $error("Row did not wrap at frame end");

	property p_sec_pol;
		@(posedge CLK) disable iff (RESET)
		CE && !primary |=> pol_r == $past(fr_s2_r);
	endproperty
	a_sec_pol: assert property (p_sec_pol)
		else $error("Secondary polarity does not follow its pin");

	property p_sec_row;
		@(posedge CLK) disable iff (RESET)
		CE && !primary && fr_edge |=> row_r == '0;
	endproperty
	a_sec_row: assert property (p_sec_row)
		else $error("Secondary row not restarted on polarity edge");

endmodule : ltpc_top

// ==== verification/ltpc_peer_model.sv ====
// Peer driver chip that shares the display timing pins
module ltpc_peer_model #(
	parameter int ROWS = 5
) (
	input wire logic active,
	input wire logic blank_n_in,
	output logic tick,
	output logic polarity,
	output logic blank_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// ------------------------------------------------------------
	// Display clock, 320 ns period, still while inactive
	// ------------------------------------------------------------
	initial begin
		tick = 1'b0;
		polarity = 1'b0;
		cnt = 0;
		forever begin
			#160;
			if (active) begin
				tick = ~tick;
				if (tick) cnt++;
				if (tick && cnt % ROWS == 0) polarity = ~polarity;
			end
		end
	end
	assign blank_n = blank_n_in;
endmodule : ltpc_peer_model

// ==== verification/lcd_timing_power_control_bench.sv ====
// Testbench of the LCD timing and power control
module lcd_timing_power_control_bench import ltpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 5;
	typedef struct packed {
		logic [2:0] sel;
		logic [5:0] dat;
		logic [6:0] exp;
	} ltpc_row_t;
	logic clk, reset, ce, wr_s, prim, osc, pix, act, bl_in, rtick;
	logic tk_o, tk_oe, pl_o, pl_oe, bn_o, bn_oe, p_tk, p_pl, p_bn;
	logic [2:0] sel, sup;
	logic [5:0] dat, con;
	logic [6:0] probe, row, gain;
	logic [1:0] lvl;
	int err_count, comparisons;
	wire tk_w = tk_oe ? tk_o : p_tk;
	wire pl_w = pl_oe ? pl_o : p_pl;
	wire bn_w = bn_oe ? bn_o : p_bn;
	ltpc_row_t tbl [16] = '{'{3'h0, 6'h07, 7'h07}, '{3'h0, 6'h03, 7'h03},
		'{3'h0, 6'h01, 7'h01}, '{3'h0, 6'h00, 7'h00}, '{3'h0, 6'h05, 7'h05},
		'{3'h1, 6'h00, 7'h3F}, '{3'h1, 6'h3F, 7'h00}, '{3'h1, 6'h25, 7'h1A},
		'{3'h2, 6'h00, 7'h1E}, '{3'h2, 6'h01, 7'h23}, '{3'h2, 6'h02, 7'h28},
		'{3'h2, 6'h03, 7'h2D}, '{3'h2, 6'h04, 7'h32}, '{3'h2, 6'h05, 7'h37},
		'{3'h2, 6'h06, 7'h3C}, '{3'h2, 6'h07, 7'h40}};
	ltpc_top #(.ROWS(N)) dut (.CLK(clk), .RESET(reset), .CE(ce),
		.CMD_WR(wr_s), .CMD_SEL(sel), .CMD_DATA(dat), .PRIMARY_SEL(prim),
		.OSCILLATOR_SOURCE_SELECT(osc), .DISPLAY_TICK_PIN_I(tk_w),
		.DISPLAY_TICK_PIN_O(tk_o), .DISPLAY_TICK_PIN_OE(tk_oe),
		.AC_DRIVE_POLARITY_I(pl_w), .AC_DRIVE_POLARITY_O(pl_o),
		.AC_DRIVE_POLARITY_OE(pl_oe), .DISPLAY_BLANK_N_I(bn_w),
		.DISPLAY_BLANK_N_O(bn_o), .DISPLAY_BLANK_N_OE(bn_oe),
		.PIXEL_BIT(pix), .PROBE_ROW(probe), .ROW_INDEX(row),
		.ROW_TICK(rtick), .DRIVE_LEVEL(lvl), .SUPPLY_EN(sup),
		.CONTRAST_LEVEL(con), .GAIN_X10(gain));
	ltpc_peer_model #(.ROWS(N)) peer (.active(act), .blank_n_in(bl_in),
		.tick(p_tk), .polarity(p_pl), .blank_n(p_bn));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [6:0] got,
			input logic [6:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [2:0] s, input logic [5:0] d);
		sel <= s;
		dat <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : wr
	task automatic wtick();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rtick !== 1'b1 && n < 60);
		check("row tick", 7'(n < 60), 7'h01);
	endtask : wtick
	function automatic logic [6:0] out(input logic [2:0] s);
		return (s == 3'h0) ? {4'h0, sup} : (s == 3'h1) ? {1'b0, con} : gain;
	endfunction : out
	task automatic results();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#400000;
		err_count++;
		results();
	end
	initial begin
		int t;
		logic p;
		{reset, ce, wr_s, prim, osc, pix, act, bl_in} = 8'hC0;
		{sel, dat, probe} = 16'h0000;
		err_count = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("contrast rst", {1'b0, con}, 7'h3F);
		check("gain rst", gain, 7'h1E);
		check("supply rst", {4'h0, sup}, 7'h00);
		prim <= 1'b1;
		osc <= 1'b1;
		repeat (4) @(posedge clk);
		check("tick oe", 7'(tk_oe), 7'h01);
		check("pol oe", 7'(pl_oe), 7'h01);
		check("blank oe", 7'(bn_oe), 7'h01);
		$display("test straps done");
		foreach (tbl[i]) begin
			wr(tbl[i].sel, tbl[i].dat);
			check("table", out(tbl[i].sel), tbl[i].exp);
		end
		wr(3'h5, 6'h2A);
		ce <= 1'b0;
		wr(3'h1, 6'h00);
		ce <= 1'b1;
		check("hold contrast", {1'b0, con}, 7'h1A);
		check("hold gain", gain, 7'h40);
		$display("test commands done");
		for (int r = 0; r < 2; r++) begin
			wr(3'h3, 6'(r));
			wtick();
			t = row;
			repeat (6) begin
				wtick();
				check("row step", row, 7'((r ? t + N - 1 : t + 1) % N));
				t = row;
			end
		end
		for (int j = 0; j < 2; j++) begin
			t = 0;
			p = pl_o;
			while (pl_o === p && t < 40) begin
				wtick();
				t++;
			end
		end
		check("frame ticks", 7'(t), 7'(N));
		wr(3'h4, 6'h01);
		check("blank on", 7'(bn_o), 7'h01);
		pix <= 1'b1;
		probe <= 7'h7F;
		wtick();
		check("tick pin", 7'(tk_o), 7'h01);
		repeat (3) @(posedge clk);
		check("level unscanned", 7'(lvl), 7'({1'b0, ~pl_o}));
		probe <= row;
		repeat (3) @(posedge clk);
		check("level scanned", 7'(lvl), 7'({1'b1, pl_o}));
		wr(3'h4, 6'h00);
		check("level blank", 7'(lvl), 7'h00);
		check("blank out", 7'(bn_o), 7'h00);
		$display("test timing done");
		osc <= 1'b0;
		repeat (4) @(posedge clk);
		check("tick oe pin", 7'(tk_oe), 7'h00);
		check("pol oe pin", 7'(pl_oe), 7'h01);
		// Secondary keeps the source strap low, as on the peer
		prim <= 1'b0;
		act <= 1'b1;
		repeat (4) @(posedge clk);
		check("sec oe", 7'({tk_oe, pl_oe, bn_oe}), 7'h00);
		wr(3'h0, 6'h07);
		check("sec supply", {4'h0, sup}, 7'h00);
		repeat (4) wtick();
		check("sec blank", 7'(lvl), 7'h00);
		wr(3'h3, 6'h00);
		bl_in <= 1'b1;
		probe <= 7'h7F;
		p = p_pl;
		t = 0;
		while (p_pl === p && t < 40) begin
			wtick();
			t++;
		end
		@(posedge clk);
		check("sec row sync", row, 7'h00);
		repeat (2) @(posedge clk);
		check("sec level", 7'(lvl), 7'({1'b0, ~p_pl}));
		$display("test secondary done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wr(3'h2, 6'h03);
		check("rst contrast", {1'b0, con}, 7'h3F);
		check("rst gain", gain, 7'h2D);
		$display("test reset done");
		results();
	end
endmodule : lcd_timing_power_control_bench
